// ### flash_ctl_defines.svh
// Purpose: Constants for the flash program/erase controller.
// Assumes: APB byte addresses on 16 bits; 8-bit data in the low lane.
// Notes:   Array index is 11 bits: user space low, top page high.
//
// Behaviour
// RL1: Erased bits read 0, programmed read 1
// RL2: 2031 user, 14 vector, one protect byte (code decodes 2032 user bytes, 7800 to 7fef, and all 16 top-page bytes)
// RL3: Fixed addresses for user, control, protect, vectors
// RL4: User array in rows of eight bytes
// RL5: Program per byte, erase per block
// RL6: Software erases row after eight programs
// RL7: Pump clock is bus or bus/2
// RL8: Software avoids operations below 2 MHz bus
// RL9: High voltage set needs select and sequence
// RL10: Margin select refused while high voltage on
// RL11: Program and erase select never both set
// RL12: High voltage enable runs pump
// RL13: Software selects erase with size, divider
// RL14: Software reads protect byte before high voltage
// RL15: Array write latches the erase block address
// RL16: Software times high voltage and recovery
// RL17: Steps ordered, unrelated accesses tolerated
// RL18: Size bits choose 2K, 1K, 64, 8
// RL19: All control bits read and write
// RL20: Protected target clears the select bits
// RL21: Reading protect byte latches its contents
// RL22: Program select latches next write address, data
// RL23: Unselected array writes change nothing
`ifndef FLASH_CTL_DEFINES_SVH
`define FLASH_CTL_DEFINES_SVH

// Sizes
`define USER_BYTES    2031
`define VECTOR_BYTES  14
`define ROW_BYTES     8

// Bus addresses
`define USER_BASE     16'h7800
`define USER_LAST     16'h7fef
`define CTRL_ADDR     16'hfe08
`define PROT_ADDR     16'hfff0
`define HIGH_PAGE     12'hfff

// Array index of the top page and the protect byte
`define HIGH_IDX_TOP  7'h7f
`define PROT_IDX      11'h7f0

// Control register fields
`define CTL_PROG      0
`define CTL_ERASE     1
`define CTL_MARGIN    2
`define CTL_HV        3
`define CTL_BLK_LO    4
`define CTL_BLK_HI    5
`define CTL_DIV       6
`define CTL_RESET     8'h00

// Care masks on the array index per block size
`define BLK_MASK_FULL 11'h000
`define BLK_MASK_HALF 11'h400
`define BLK_MASK_8ROW 11'h7c0
`define BLK_MASK_ROW  11'h7f8
`define BLK_MASK_BYTE 11'h7ff

// Protect region starts, as array index
`define PROT_START0   11'h000
`define PROT_START1   11'h080
`define PROT_START2   11'h100
`define PROT_START3   11'h200

`endif

// ### flash_ctl_pkg.sv
// Purpose: Types for the flash program/erase controller.
// Assumes: Constants come from flash_ctl_defines.svh.
// Notes:   Sequence states are Gray coded along the usual path.
package flash_ctl_pkg;

  typedef enum logic [2:0] {
    SQ_IDLE  = 3'h0,
    SQ_SEL   = 3'h1,
    SQ_PROT  = 3'h3,
    SQ_ARMED = 3'h2,
    SQ_HV    = 3'h6,
    SQ_DONE  = 3'h7
  } seq_e;

  typedef logic [10:0] idx_t;
  typedef logic [7:0]  byte_t;

endpackage : flash_ctl_pkg

// ### nvm_array.sv
// Purpose: Byte array of the non-volatile store.
// Assumes: One write port, one combinational read port.
// Notes:   No reset: contents model non-volatile cells, delivered erased.
`timescale 1ns/100ps
module nvm_array #(
  parameter int AW    = 11,
  parameter int DEPTH = 2048
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic          or_mode,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);
  // Cells leave the factory erased, so the protect byte reads open
  logic [7:0] mem [DEPTH] = '{default: 8'h00};

  if (DEPTH != (1 << AW)) begin : g_chk
    $error("nvm_array: DEPTH must equal 2**AW");
  end

  // Programming only sets bits; erase writes zeros
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= or_mode ? (mem[waddr] | wdata) : wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule : nvm_array

// ### pump_clock.sv
// Purpose: Charge-pump clock tick derived from the bus clock.
// Assumes: Runs only while high voltage is enabled.
// Notes:   Tick high every cycle for divide 1, every other for 2.
`timescale 1ns/100ps
module pump_clock (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  input  wire logic div2,
  output logic      tick
);
  logic phase_r;
  logic tick_r;

  // RL7 divide by one or two
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r <= 1'b0;
      tick_r  <= 1'b0;
    end else begin
      phase_r <= run ? ~phase_r : 1'b0;
      tick_r  <= run & (~div2 | phase_r);
    end
  end

  assign tick = tick_r;
endmodule : pump_clock

// ### flash_ctl.sv
// Purpose: APB-attached program/erase sequencer of the flash array.
// Assumes: Zero-wait APB slave; software times the high-voltage steps.
// Notes:   Array writes only arm an operation; cells change under HV.
`timescale 1ns/100ps
`include "flash_ctl_defines.svh"
module flash_ctl
  import flash_ctl_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [15:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             HV_ON,
  output logic             MARGIN_ON,
  output logic             PUMP_TICK
);

  ////////////////////////////////////////////////////////////////////
  // Declarations
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic        prog_r;
  logic        erase_r;
  logic        margin_r;
  logic        hv_r;
  logic [1:0]  blk_r;
  logic        div_r;
  logic        prog_nxt;
  logic        erase_nxt;
  logic        margin_nxt;
  logic        hv_nxt;
  seq_e        st_r;
  logic [3:0]  bpr_r;
  idx_t        tgt_idx_r;
  byte_t       tgt_dat_r;
  idx_t        base_r;
  idx_t        end_r;
  idx_t        sw_r;
  logic        swact_r;
  logic        setup;
  logic        acc;
  logic        wr_ev;
  logic        rd_ev;
  logic        hit_ctl;
  logic        hit_user;
  logic        hit_high;
  logic        hit_arr;
  logic        wr_ctl;
  logic        wr_arr;
  logic        sel;
  idx_t        arr_idx;
  byte_t       arr_rdata;
  byte_t       ctl_val;
  byte_t       w;
  idx_t        cmask;
  idx_t        w_base;
  idx_t        w_end;
  logic        prot_hit;
  logic        tgt_take;
  logic        prot_kill;
  logic        arr_we;
  logic        arr_wor;
  byte_t       arr_wdata;
  logic        pump_tick_w;

  function automatic idx_t prot_start(input logic [3:0] b);
    if (b[0]) begin
      return `PROT_START0;
    end else if (b[1]) begin
      return `PROT_START1;
    end else if (b[2]) begin
      return `PROT_START2;
    end else begin
      return `PROT_START3;
    end
  endfunction : prot_start

  ////////////////////////////////////////////////////////////////////
  // Address decode
  assign setup = PSEL & ~PENABLE;
  assign acc   = PSEL & PENABLE & pready_r;
  assign wr_ev = acc & PWRITE;
  assign rd_ev = acc & ~PWRITE;
  assign sel   = prog_r | erase_r;

  // RL3 fixed address map
  always_comb begin
    hit_ctl  = 1'b0;
    hit_user = 1'b0;
    hit_high = 1'b0;
    if (PADDR == `CTRL_ADDR) begin
      hit_ctl = 1'b1;
    end else if (PADDR >= `USER_BASE && PADDR <= `USER_LAST) begin
      hit_user = 1'b1;
    end else if (PADDR[15:4] == `HIGH_PAGE) begin
      hit_high = 1'b1;
    end
  end

  // RL2 user bytes, vectors and protect byte fill one index space
  assign hit_arr = hit_user | hit_high;
  assign arr_idx = hit_high ? {`HIGH_IDX_TOP, PADDR[3:0]} : PADDR[10:0];
  assign wr_ctl  = wr_ev & hit_ctl;
  assign wr_arr  = wr_ev & hit_arr;

  // RL19 every control bit reads back
  always_comb begin
    ctl_val              = `CTL_RESET;
    ctl_val[`CTL_PROG]   = prog_r;
    ctl_val[`CTL_ERASE]  = erase_r;
    ctl_val[`CTL_MARGIN] = margin_r;
    ctl_val[`CTL_HV]     = hv_r;
    ctl_val[`CTL_BLK_LO] = blk_r[0];
    ctl_val[`CTL_BLK_HI] = blk_r[1];
    ctl_val[`CTL_DIV]    = div_r;
  end

  ////////////////////////////////////////////////////////////////////
  // APB slave: answer in the first access cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~(hit_ctl | hit_arr);
      if (setup & ~PWRITE & hit_ctl) begin
        prdata_r <= {24'h0, ctl_val};
      end else if (setup & ~PWRITE & hit_arr) begin
        // RL1 stored cell values read as is
        prdata_r <= {24'h0, arr_rdata};
      end else if (setup) begin
        prdata_r <= 32'h0;
      end
    end
  end

  assign PREADY  = pready_r;
  assign PSLVERR = pslverr_r;
  assign PRDATA  = prdata_r;

  ////////////////////////////////////////////////////////////////////
  // Target range and protection check
  // RL18 size bits pick cared address bits
  always_comb begin
    case (blk_r)
      2'b00:   cmask = `BLK_MASK_FULL;
      2'b01:   cmask = `BLK_MASK_HALF;
      2'b10:   cmask = `BLK_MASK_8ROW;
      default: cmask = `BLK_MASK_ROW;
    endcase
    // RL5 program acts on one byte only
    if (prog_r) begin
      cmask = `BLK_MASK_BYTE;
    end
  end

  // RL4 rows of eight align on index bits
  assign w_base = arr_idx & cmask;
  assign w_end  = arr_idx | ~cmask;

  // RL20 protected range or protect byte itself
  assign prot_hit = (arr_idx == `PROT_IDX) |
                    ((|bpr_r) & (w_end >= prot_start(bpr_r)));
  assign prot_kill = (st_r == SQ_PROT) & wr_arr & prot_hit;
  assign tgt_take  = (st_r == SQ_PROT) & wr_arr & ~prot_hit;

  ////////////////////////////////////////////////////////////////////
  // Control register
  assign w = PWDATA[7:0];

  always_comb begin
    prog_nxt   = prog_r;
    erase_nxt  = erase_r;
    hv_nxt     = hv_r;
    margin_nxt = margin_r;
    if (wr_ctl) begin
      // RL11 a set is refused while the other is set
      prog_nxt  = w[`CTL_PROG] & ~erase_r & ~(w[`CTL_ERASE] & ~prog_r);
      erase_nxt = w[`CTL_ERASE] & ~prog_r & ~(w[`CTL_PROG] & ~erase_r);
      // RL9 only once the sequence is armed
      hv_nxt = w[`CTL_HV] & (prog_nxt | erase_nxt) &
               (st_r == SQ_ARMED || st_r == SQ_HV);
      // RL10 margin stays clear under high voltage
      margin_nxt = w[`CTL_MARGIN] & ~hv_r & ~hv_nxt;
    end
    // RL20 protection drops the selection
    if (prot_kill) begin
      prog_nxt  = 1'b0;
      erase_nxt = 1'b0;
      hv_nxt    = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      prog_r   <= 1'b0;
      erase_r  <= 1'b0;
      hv_r     <= 1'b0;
      margin_r <= 1'b0;
      blk_r    <= 2'b00;
      div_r    <= 1'b0;
    end else begin
      prog_r   <= prog_nxt;
      erase_r  <= erase_nxt;
      hv_r     <= hv_nxt;
      margin_r <= margin_nxt;
      if (wr_ctl) begin
        blk_r <= {w[`CTL_BLK_HI], w[`CTL_BLK_LO]};
        div_r <= w[`CTL_DIV];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Operation sequence
  // RL17 unrelated accesses leave the state alone
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_r <= SQ_IDLE;
    end else begin
      case (st_r)
        SQ_IDLE: begin
          if (sel) begin
            st_r <= SQ_SEL;
          end
        end
        SQ_SEL: begin
          if (!sel) begin
            st_r <= SQ_IDLE;
          end else if (rd_ev && PADDR == `PROT_ADDR) begin
            st_r <= SQ_PROT;
          end
        end
        SQ_PROT: begin
          if (!sel || prot_kill) begin
            st_r <= SQ_IDLE;
          end else if (tgt_take) begin
            st_r <= SQ_ARMED;
          end
        end
        SQ_ARMED: begin
          if (!sel) begin
            st_r <= SQ_IDLE;
          end else if (hv_r) begin
            st_r <= SQ_HV;
          end
        end
        SQ_HV: begin
          if (!hv_r) begin
            st_r <= SQ_DONE;
          end
        end
        default: begin
          if (!sel) begin
            st_r <= SQ_IDLE;
          end
        end
      endcase
    end
  end

  // RL21 protect byte copied on each read
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bpr_r <= 4'h0;
    end else if (rd_ev && PADDR == `PROT_ADDR) begin
      bpr_r <= arr_rdata[3:0];
    end
  end

  // RL15 RL22 latch target of the arming write
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tgt_idx_r <= '0;
      tgt_dat_r <= 8'h00;
      base_r    <= '0;
      end_r     <= '0;
    end else if (tgt_take) begin
      tgt_idx_r <= arr_idx;
      tgt_dat_r <= w;
      base_r    <= w_base;
      end_r     <= w_end;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // High-voltage engine: one cell per pump tick
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sw_r    <= '0;
      swact_r <= 1'b0;
    end else if (st_r == SQ_ARMED && hv_r) begin
      sw_r    <= base_r;
      swact_r <= 1'b1;
    end else if (st_r == SQ_HV && hv_r) begin
      if (swact_r && pump_tick_w) begin
        if (sw_r == end_r) begin
          swact_r <= 1'b0;
        end else begin
          sw_r <= sw_r + 11'h001;
        end
      end
    end else begin
      swact_r <= 1'b0;
    end
  end

  // RL23 cells change only under high voltage
  assign arr_we = (st_r == SQ_HV) & hv_r & swact_r & pump_tick_w &
                  (sw_r != `PROT_IDX);
  assign arr_wor = prog_r;
  // RL1 erase writes zeros, program ORs ones
  assign arr_wdata = erase_r ? 8'h00 : tgt_dat_r;

  nvm_array #(
    .AW    (11),
    .DEPTH (2048)
  ) u_array (
    .clk   (CLK),
    .we    (arr_we),
    .or_mode (arr_wor),
    .waddr (sw_r),
    .wdata (arr_wdata),
    .raddr (arr_idx),
    .rdata (arr_rdata)
  );

  // RL12 pump runs with high voltage
  pump_clock u_pump (
    .clk  (CLK),
    .rst  (RST),
    .run  (hv_r),
    .div2 (div_r),
    .tick (pump_tick_w)
  );

  assign HV_ON     = hv_r;
  assign MARGIN_ON = margin_r;
  assign PUMP_TICK = pump_tick_w;

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_interlock;
    !(prog_r && erase_r);
  endproperty
  a_interlock: assert property (p_interlock) // RL11
    else $error("program and erase select both set");

  property p_hv_needs_sel;
    hv_r |-> (prog_r || erase_r);
  endproperty
  a_hv_needs_sel: assert property (p_hv_needs_sel) // RL9
    else $error("high voltage without a selection");

  property p_hv_from_armed;
    $rose(hv_r) |-> ($past(st_r) == SQ_ARMED || $past(st_r) == SQ_HV);
  endproperty
  a_hv_from_armed: assert property (p_hv_from_armed) // RL9
    else $error("high voltage set before sequence done");

  property p_margin_refused;
    (wr_ctl && hv_r) |=> !margin_r;
  endproperty
  a_margin_refused: assert property (p_margin_refused) // RL10
    else $error("margin set under high voltage");

  property p_ctl_readback;
    (setup && !PWRITE && hit_ctl) |=> PRDATA[7:0] == $past(ctl_val);
  endproperty
  a_ctl_readback: assert property (p_ctl_readback) // RL19
    else $error("control read data mismatch");

  property p_prot_latch;
    (rd_ev && PADDR == `PROT_ADDR) |=> bpr_r == $past(arr_rdata[3:0]);
  endproperty
  a_prot_latch: assert property (p_prot_latch) // RL21
    else $error("protect byte not latched");

  property p_prot_kill;
    prot_kill |=> (!prog_r && !erase_r && st_r == SQ_IDLE);
  endproperty
  a_prot_kill: assert property (p_prot_kill) // RL20
    else $error("protected target kept its selection");

  property p_no_idle_write;
    arr_we |-> (st_r == SQ_HV && hv_r);
  endproperty
  a_no_idle_write: assert property (p_no_idle_write) // RL23
    else $error("array written without high voltage");

  property p_target_latch;
    tgt_take |=> (tgt_idx_r == $past(arr_idx) && tgt_dat_r == $past(w));
  endproperty
  a_target_latch: assert property (p_target_latch) // RL22
    else $error("target address or data not latched");

  property p_pump_stops;
    !hv_r ##1 1'b1 |-> !pump_tick_w;
  endproperty
  a_pump_stops: assert property (p_pump_stops) // RL12
    else $error("pump ticking without high voltage");

  property p_erase_zero;
    (arr_we && erase_r) |-> (arr_wdata == 8'h00 && !arr_wor);
  endproperty
  a_erase_zero: assert property (p_erase_zero) // RL1
    else $error("erase writes nonzero data");

  property p_cov_erase;
    (st_r == SQ_HV && erase_r && arr_we);
  endproperty
  c_cov_erase: cover property (p_cov_erase);

  property p_cov_prog;
    (st_r == SQ_HV && prog_r && arr_we);
  endproperty
  c_cov_prog: cover property (p_cov_prog);

  property p_cov_kill;
    prot_kill;
  endproperty
  c_cov_kill: cover property (p_cov_kill);

  property p_cov_margin;
    (wr_ctl && hv_r && w[`CTL_MARGIN]);
  endproperty
  c_cov_margin: cover property (p_cov_margin);

endmodule : flash_ctl

// ### cpu_model.sv
// Purpose: Bus master model running program/erase software.
// Assumes: Slave answers with pready; software times HV.
// Notes:   One idle cycle follows every transfer.
`timescale 1ns/100ps
`include "flash_ctl_defines.svh"
module cpu_model (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [15:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 16'h0000;
    pwdata  = 32'h0000_0000;
  end
  //////////////////////////////////////////////////////////////
  // Request held until pready is seen at a rising edge, released there
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] r, output logic e);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    xfer(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] r, output logic e);
    xfer(1'b0, a, 8'h00, r, e);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  //////////////////////////////////////////////////////////////
  task automatic arm(input logic [7:0] ctl, input logic [15:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    wr(`CTRL_ADDR, ctl);
    rd(`PROT_ADDR, r, e);
    rd(`USER_BASE, r, e);
    wr(a, d);
    wr(`CTRL_ADDR, ctl | 8'h08);
  endtask : arm
  task automatic finish(input logic [7:0] ctl);
    wr(`CTRL_ADDR, ctl);
    idle(4);
    wr(`CTRL_ADDR, 8'h00);
    idle(4);
  endtask : finish
endmodule : cpu_model

// ### flash_program_erase_control_tb.sv
// Purpose: Self-checking bench of the flash program/erase controller.
// Assumes: Array cells start erased, protect byte open.
// Notes:   Software steps come from cpu_model.
`timescale 1ns/100ps
`include "flash_ctl_defines.svh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("[FAIL] %s exp=%h got=%h", nm, ex, got); end end
module flash_program_erase_control_tb;
  import flash_ctl_pkg::*;
  logic        clk;
  logic        rst;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        hv_on, margin_on, pump_tick;
  int          error_cnt;
  int          total_checks;
  byte_t       rv;
  logic        re;

  flash_ctl dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .HV_ON(hv_on), .MARGIN_ON(margin_on), .PUMP_TICK(pump_tick));
  cpu_model u_cpu (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // bus clock 125 MHz, far above 2 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////
  task automatic rchk(input logic [15:0] a, input byte_t ex, input string nm);
    u_cpu.rd(a, rv, re);
    `CHK(nm, ex, rv)
  endtask : rchk
  task automatic ticks(output int c);
    c = 0;
    repeat (8) begin
      @(negedge clk);
      c += int'(pump_tick === 1'b1);
    end
    @(posedge clk);
  endtask : ticks
  task automatic prog(input logic [15:0] a, input byte_t d);
    u_cpu.arm(8'h01, a, d);
    u_cpu.idle(8);
    u_cpu.finish(8'h01);
  endtask : prog
  task automatic erase(input logic [1:0] b, input logic dv, input logic [15:0] a, input int n);
    u_cpu.arm({1'b0, dv, b, 4'h2}, a, 8'hff);
    u_cpu.idle(n);
    u_cpu.finish({1'b0, dv, b, 4'h2});
  endtask : erase
  //////////////////////////////////////////////////////////////
  task automatic t_reset;
    `CHK("hv_on", 1'b0, hv_on)
    rchk(`CTRL_ADDR, 8'h00, "ctl_reset");
    u_cpu.rd(16'h7ff0, rv, re);
    `CHK("gap_err", 1'b1, re)
    `CHK("gap_data", 8'h00, rv)
    $display("test reset done");
  endtask : t_reset
  task automatic t_bits;
    byte_t v [8] = '{8'h01, 8'h04, 8'h02, 8'h10, 8'h20, 8'h40, 8'h80, 8'h08};
    byte_t x [8] = '{8'h01, 8'h04, 8'h02, 8'h10, 8'h20, 8'h40, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      u_cpu.wr(`CTRL_ADDR, v[i]);
      rchk(`CTRL_ADDR, x[i], "ctl_bit");
      `CHK("margin_on", v[i] == 8'h04, margin_on)
    end
    u_cpu.wr(`CTRL_ADDR, 8'h01);
    u_cpu.wr(`CTRL_ADDR, 8'h03);
    rchk(`CTRL_ADDR, 8'h01, "both_sel");
    u_cpu.wr(`CTRL_ADDR, 8'h02);
    rchk(`CTRL_ADDR, 8'h00, "swap_sel");
    u_cpu.wr(`CTRL_ADDR, 8'h03);
    rchk(`CTRL_ADDR, 8'h00, "both_idle");
    $display("test control bits done");
  endtask : t_bits
  task automatic t_full;
    int c;
    u_cpu.arm(8'h02, `USER_BASE, 8'h5a);
    `CHK("hv_set", 1'b1, hv_on)
    ticks(c);
    `CHK("tick_div1", 8, c)
    u_cpu.wr(`CTRL_ADDR, 8'h0e);
    rchk(`CTRL_ADDR, 8'h0a, "margin_hv");
    `CHK("margin_on", 1'b0, margin_on)
    u_cpu.idle(2100);
    u_cpu.finish(8'h02);
    `CHK("hv_clr", 1'b0, hv_on)
    ticks(c);
    `CHK("tick_off", 0, c)
    rchk(`USER_BASE, 8'h00, "erased_lo");
    rchk(`USER_LAST, 8'h00, "erased_hi");
    $display("test full erase done");
  endtask : t_full
  task automatic t_blocks;
    logic [15:0] pa [4] = '{16'h7808, 16'h7840, 16'h7c00, 16'h7807};
    logic [15:0] ea [4] = '{16'h780c, 16'h7850, 16'h7c10, 16'h7801};
    int          cy [4] = '{20, 80, 1100, 4200};
    for (int i = 0; i < 4; i++) begin
      prog(pa[i], 8'h81 >> i);
    end
    rchk(16'h7808, 8'h81, "prog_byte");
    rchk(16'h7809, 8'h00, "prog_next");
    u_cpu.wr(16'h7808, 8'hff);
    rchk(16'h7808, 8'h81, "unsel_wr");
    for (int i = 0; i < 4; i++) begin
      erase(2'(3 - i), 1'(i == 3), ea[i], cy[i]);
      rchk(pa[i], 8'h00, "blk_erased");
      if (i < 3) rchk(pa[3], 8'h10, "blk_kept");
    end
    $display("test block erase done");
  endtask : t_blocks
  task automatic t_prot;
    u_cpu.wr(`CTRL_ADDR, 8'h02);
    u_cpu.rd(`PROT_ADDR, rv, re);
    u_cpu.wr(`PROT_ADDR, 8'h00);
    rchk(`CTRL_ADDR, 8'h00, "sel_clr");
    u_cpu.wr(`CTRL_ADDR, 8'h0a);
    `CHK("hv_prot", 1'b0, hv_on)
    rchk(`CTRL_ADDR, 8'h02, "hv_refused");
    u_cpu.finish(8'h00);
    $display("test protection done");
  endtask : t_prot
  //////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  initial begin
    error_cnt    = 0;
    total_checks = 0;
    rst          = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_bits();
    t_full();
    t_blocks();
    t_prot();
    print_verdict();
  end
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    $display("[FAIL] watchdog exp=done got=hang");
    print_verdict();
  end
endmodule : flash_program_erase_control_tb
